// *** hdl/pmc_pkg.sv ***
/*
 * constants and types for the power-mode controller.
 * assumes one 20 MHz system clock domain; no register bus, all bits are ports.
 */
package pmc_pkg;
	typedef enum logic [2:0] {
		PMC_RUN     = 3'b000,
		PMC_IDLE    = 3'b001,
		PMC_WAKEUP  = 3'b011,
		PMC_SLEEP   = 3'b010,
		PMC_DEEP    = 3'b110,
		PMC_BACKUP  = 3'b111
	} pmc_state_e;

	localparam int unsigned PMC_CLK_HZ        = 20_000_000;
	localparam int unsigned PMC_OSC_START_US  = 1000;
	localparam int unsigned PMC_PLL_LOCK_US   = 100;
	localparam int unsigned PMC_OSC_START_CYC = PMC_OSC_START_US * (PMC_CLK_HZ / 1_000_000);
	localparam int unsigned PMC_PLL_LOCK_CYC  = PMC_PLL_LOCK_US * (PMC_CLK_HZ / 1_000_000);
	localparam int unsigned PMC_PRIO_W        = 3;
	localparam int unsigned PMC_NUM_PERIPH    = 8;
	localparam int unsigned PMC_BANK_WORDS    = 32;
	localparam logic [1:0]  PMC_DIV_RESET     = 2'h0;
	localparam logic [2:0]  PMC_DIVCNT_RESET  = 3'h0;
	localparam logic [1:0]  PMC_DIV_BY1       = 2'h0;
	localparam logic [1:0]  PMC_DIV_BY2       = 2'h1;
	localparam logic [1:0]  PMC_DIV_BY4       = 2'h2;
	localparam logic [1:0]  PMC_DIV_BY8       = 2'h3;
	localparam logic [2:0]  PMC_MASK_BY1      = 3'h0;
	localparam logic [2:0]  PMC_MASK_BY2      = 3'h1;
	localparam logic [2:0]  PMC_MASK_BY4      = 3'h3;
	localparam logic [2:0]  PMC_MASK_BY8      = 3'h7;
endpackage

// *** hdl/pmc_power_mode_controller.sv ***
/*
 * power-mode controller: halt entry, wake decisions, bus clock divisor,
 * read latency, oscillator restart delay and deep-sleep/backup retention.
 * assumes a single clock domain; core, interrupt controller and supply monitor
 * signals are synchronous, except the supply-good and pin inputs which are
 * synchronised here.
 */
`timescale 1ns/10ps
module pmc_power_mode_controller #(
	parameter int unsigned OSC_START_CYC = pmc_pkg::PMC_OSC_START_CYC,
	parameter int unsigned PLL_LOCK_CYC  = pmc_pkg::PMC_PLL_LOCK_CYC,
	parameter int unsigned NUM_PERIPH    = pmc_pkg::PMC_NUM_PERIPH
) (
	input  wire logic                          core_clk_in,
	input  wire logic                          resetn_in,
	input  wire logic                          clk_en_in,
	input  wire logic                          halt_instr_in,
	input  wire logic                          sleep_on_wait_select_in,
	input  wire logic                          deep_sleep_select_in,
	input  wire logic                          calendar_off_in_deep_sleep_in,
	input  wire logic                          retained_store_enable_in,
	input  wire logic                          deep_watchdog_enable_in,
	input  wire logic [1:0]                    peripheral_clock_divisor_in,
	input  wire logic [NUM_PERIPH-1:0]         stop_in_idle_in,
	input  wire logic                          irq_pending_in,
	input  wire logic                          irq_sleep_capable_in,
	input  wire logic [pmc_pkg::PMC_PRIO_W-1:0] irq_priority_in,
	input  wire logic [pmc_pkg::PMC_PRIO_W-1:0] cpu_priority_in,
	input  wire logic                          device_reset_in,
	input  wire logic                          watchdog_timeout_in,
	input  wire logic                          src_needs_osc_start_in,
	input  wire logic                          src_uses_pll_in,
	input  wire logic                          main_supply_good_in,
	input  wire logic                          master_clear_pin_in,
	input  wire logic                          external_interrupt_zero_in,
	input  wire logic                          periph_read_req_in,
	output logic                               cpu_halt_out,
	output logic                               system_clock_run_out,
	output logic                               peripheral_bus_clock_en_out,
	output logic                               system_clock_domain_run_out,
	output logic [NUM_PERIPH-1:0]              periph_clk_en_out,
	output logic                               periph_read_done_out,
	output logic                               fail_safe_clock_monitor_en_out,
	output logic                               brownout_reset_en_out,
	output logic                               watchdog_clear_out,
	output logic                               core_power_on_out,
	output logic                               calendar_clock_on_out,
	output logic                               deep_sleep_watchdog_on_out,
	output logic                               retained_store_bank_on_out,
	output logic                               always_retained_store_on_out,
	output logic                               master_clear_filter_on_out,
	output logic                               ext_int_zero_wake_out,
	output logic                               power_on_reset_out,
	output logic [2:0]                         mode_out
);
	import pmc_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [2:0] div_mask(input logic [1:0] code);
		case (code)
			PMC_DIV_BY1: div_mask = PMC_MASK_BY1;
			PMC_DIV_BY2: div_mask = PMC_MASK_BY2;
			PMC_DIV_BY4: div_mask = PMC_MASK_BY4;
			PMC_DIV_BY8: div_mask = PMC_MASK_BY8;
			default:     div_mask = PMC_MASK_BY1;
		endcase
	endfunction

	localparam int unsigned DLY_W = $clog2(OSC_START_CYC + PLL_LOCK_CYC + 2);

	// ------------------------------------------------------------
	// synchronisers for supply and pins
	// ------------------------------------------------------------
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else if (clk_en_in) begin
			sync1_reg <= {external_interrupt_zero_in, master_clear_pin_in, main_supply_good_in};
			sync2_reg <= sync1_reg;
		end
	end

	logic supply_good;
	logic master_clear_pin_sync;
	logic external_interrupt_zero_sync;
	assign supply_good = sync2_reg[0];
	assign master_clear_pin_sync   = sync2_reg[1];
	assign external_interrupt_zero_sync   = sync2_reg[2];

	// ------------------------------------------------------------
	// wake decision
	// ------------------------------------------------------------
	logic irq_above;
	logic hard_wake;
	logic wake_hard_reg;
	assign irq_above = irq_pending_in && (irq_priority_in > cpu_priority_in);
	assign hard_wake = device_reset_in || watchdog_timeout_in;

	// ------------------------------------------------------------
	// mode state machine
	// ------------------------------------------------------------
	pmc_state_e        state_reg;
	logic [DLY_W-1:0]  delay_reg;
	logic              cal_off_reg;
	logic              bank_keep_reg;
	logic              deep_wdt_reg;
	logic              por_reg;

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg <= PMC_RUN;
			delay_reg <= '0;
		end else if (clk_en_in) begin
			if (!supply_good) begin
				state_reg <= PMC_BACKUP;
			end else begin
				case (state_reg)
					PMC_RUN: begin
						if (halt_instr_in) begin
							if (!sleep_on_wait_select_in)
								state_reg <= PMC_IDLE;
							else if (deep_sleep_select_in)
								state_reg <= PMC_DEEP;
							else
								state_reg <= PMC_SLEEP;
						end
					end
					PMC_IDLE: begin
						if (irq_above || hard_wake)
							state_reg <= PMC_RUN;
					end
					PMC_SLEEP: begin
						if (hard_wake || (irq_pending_in && irq_sleep_capable_in)) begin
							state_reg <= PMC_WAKEUP;
							delay_reg <= DLY_W'((src_needs_osc_start_in ? OSC_START_CYC : 0)
								+ (src_uses_pll_in ? PLL_LOCK_CYC : 0));
						end
					end
					PMC_WAKEUP: begin
						if (delay_reg != '0)
							delay_reg <= delay_reg - DLY_W'(1);
						else if (irq_above || hard_wake || wake_hard_reg)
							state_reg <= PMC_RUN;
						else
							state_reg <= PMC_IDLE;
					end
					PMC_DEEP: begin
						if (device_reset_in || (watchdog_timeout_in && deep_wdt_reg)
							|| !master_clear_pin_sync || external_interrupt_zero_sync)
							state_reg <= PMC_RUN;
					end
					PMC_BACKUP: begin
						state_reg <= PMC_RUN;
					end
					default: state_reg <= PMC_RUN;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// wake cause held across the oscillator restart
	// ------------------------------------------------------------
	// a one-cycle reset or time-out must still end in run after the delay
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			wake_hard_reg <= 1'b0;
		end else if (clk_en_in) begin
			if (state_reg == PMC_SLEEP)
				wake_hard_reg <= hard_wake;
			else if (state_reg != PMC_WAKEUP)
				wake_hard_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// retention settings latched at deep sleep or backup entry
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cal_off_reg   <= 1'b0;
			bank_keep_reg <= 1'b0;
			deep_wdt_reg  <= 1'b0;
		end else if (clk_en_in) begin
			if (state_reg != PMC_DEEP && state_reg != PMC_BACKUP) begin
				cal_off_reg   <= calendar_off_in_deep_sleep_in;
				bank_keep_reg <= retained_store_enable_in;
				deep_wdt_reg  <= deep_watchdog_enable_in;
			end
		end
	end

	// power-on reset pulse on supply return
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			por_reg <= 1'b0;
		else if (clk_en_in)
			por_reg <= (state_reg == PMC_BACKUP) && supply_good;
	end

	// ------------------------------------------------------------
	// peripheral bus clock divider and read latency
	// ------------------------------------------------------------
	logic [2:0] divcnt_reg;
	logic       pb_tick;
	assign pb_tick = (divcnt_reg & div_mask(peripheral_clock_divisor_in)) == 3'h0;

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in)
			divcnt_reg <= PMC_DIVCNT_RESET;
		else if (clk_en_in)
			divcnt_reg <= divcnt_reg + 3'h1;
	end

	logic read_wait_reg;
	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			read_wait_reg        <= 1'b0;
			periph_read_done_out <= 1'b0;
		end else if (clk_en_in) begin
			periph_read_done_out <= 1'b0;
			if ((periph_read_req_in || read_wait_reg) && pb_tick) begin
				read_wait_reg        <= 1'b0;
				periph_read_done_out <= 1'b1;
			end else if (periph_read_req_in) begin
				read_wait_reg <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	pmc_state_e nstate;
	logic       asleep;
	logic       awake;
	assign nstate = state_reg;
	assign asleep = (nstate == PMC_SLEEP) || (nstate == PMC_WAKEUP);
	assign awake  = (nstate == PMC_RUN) || (nstate == PMC_IDLE);

	always_ff @(posedge core_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cpu_halt_out                   <= 1'b0;
			system_clock_run_out           <= 1'b1;
			peripheral_bus_clock_en_out    <= 1'b1;
			system_clock_domain_run_out          <= 1'b1;
			periph_clk_en_out              <= '1;
			fail_safe_clock_monitor_en_out <= 1'b1;
			brownout_reset_en_out          <= 1'b1;
			watchdog_clear_out             <= 1'b0;
			core_power_on_out              <= 1'b1;
			calendar_clock_on_out          <= 1'b1;
			deep_sleep_watchdog_on_out     <= 1'b0;
			retained_store_bank_on_out     <= 1'b1;
			always_retained_store_on_out   <= 1'b1;
			master_clear_filter_on_out     <= 1'b1;
			ext_int_zero_wake_out          <= 1'b0;
			power_on_reset_out             <= 1'b0;
			mode_out                       <= 3'h0;
		end else if (clk_en_in) begin
			cpu_halt_out                   <= nstate != PMC_RUN;
			system_clock_run_out           <= awake || nstate == PMC_WAKEUP;
			peripheral_bus_clock_en_out    <= awake && pb_tick;
			system_clock_domain_run_out          <= awake;
			for (int i = 0; i < int'(NUM_PERIPH); i++)
				periph_clk_en_out[i] <= awake && pb_tick
					&& !(nstate == PMC_IDLE && stop_in_idle_in[i]);
			fail_safe_clock_monitor_en_out <= awake;
			brownout_reset_en_out          <= nstate != PMC_BACKUP;
			watchdog_clear_out             <= 1'b0;
			core_power_on_out              <= awake || asleep;
			calendar_clock_on_out          <= (awake || asleep) || !cal_off_reg;
			deep_sleep_watchdog_on_out     <= nstate == PMC_DEEP && deep_wdt_reg;
			retained_store_bank_on_out     <= (awake || asleep) || bank_keep_reg;
			always_retained_store_on_out   <= 1'b1;
			master_clear_filter_on_out     <= 1'b1;
			ext_int_zero_wake_out          <= nstate == PMC_DEEP && external_interrupt_zero_sync;
			power_on_reset_out             <= por_reg;
			mode_out                       <= nstate;
		end
	end
endmodule

// *** testbench/pmc_core_model.sv ***
/* processor core model: executes halt instructions and peripheral reads.
   assumes the controller's halt output; a halted core issues nothing. */
`timescale 1ns/10ps
module pmc_core_model (
	input  wire logic core_clk_in,
	input  wire logic cpu_halt_in,
	output logic      halt_instr_out,
	output logic      periph_read_req_out
);
	initial begin
		halt_instr_out = 1'b0;
		periph_read_req_out = 1'b0;
	end
	// one-cycle request, launched and dropped after falling edges
	task automatic issue(input logic is_read);
		@(negedge core_clk_in);
		if (cpu_halt_in !== 1'b1) begin
			periph_read_req_out = is_read;
			halt_instr_out = !is_read;
		end
		@(negedge core_clk_in);
		periph_read_req_out = 1'b0;
		halt_instr_out = 1'b0;
	endtask
endmodule

// *** testbench/pmc_checker.sv ***
/* port checks for the power-mode controller.
   bound from the bench top; one clock domain, async active-low reset. */
`timescale 1ns/10ps
module pmc_checker
	import pmc_pkg::*;
#(
	parameter int unsigned NUM_PERIPH = 8
) (
	input wire logic core_clk_in, resetn_in, clk_en_in, halt_instr_in, periph_read_req_in,
	input wire logic sleep_on_wait_select_in, deep_sleep_select_in, main_supply_good_in,
	input wire logic irq_pending_in, device_reset_in, watchdog_timeout_in,
	input wire logic [1:0] peripheral_clock_divisor_in,
	input wire logic [NUM_PERIPH-1:0] stop_in_idle_in, periph_clk_en_out,
	input wire logic [pmc_pkg::PMC_PRIO_W-1:0] irq_priority_in, cpu_priority_in,
	input wire logic cpu_halt_out, system_clock_run_out, peripheral_bus_clock_en_out,
	input wire logic system_clock_domain_run_out, periph_read_done_out, watchdog_clear_out,
	input wire logic fail_safe_clock_monitor_en_out, brownout_reset_en_out, core_power_on_out,
	input wire logic deep_sleep_watchdog_on_out, always_retained_store_on_out,
	input wire logic master_clear_filter_on_out, power_on_reset_out,
	input wire logic [2:0] mode_out
);
	logic quiet;
	logic halt_ok;
	assign quiet = (!irq_pending_in || irq_priority_in <= cpu_priority_in) && !device_reset_in
		&& !watchdog_timeout_in && main_supply_good_in;
	assign halt_ok = halt_instr_in && clk_en_in && mode_out == PMC_RUN && main_supply_good_in;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	a_idle_entry: assert property (halt_ok && !sleep_on_wait_select_in |-> ##2 mode_out == PMC_IDLE)
		else $error("halt without sleep select did not reach idle");
	a_sleep_entry: assert property (halt_ok && sleep_on_wait_select_in |->
		##2 mode_out == (deep_sleep_select_in ? PMC_DEEP : PMC_SLEEP))
		else $error("halt with sleep select reached wrong mode");
	a_halt_flag: assert property (mode_out != PMC_RUN |-> cpu_halt_out)
		else $error("core not halted outside run");
	a_sleep_gates: assert property (mode_out == PMC_SLEEP |-> !system_clock_run_out
		&& !fail_safe_clock_monitor_en_out && brownout_reset_en_out)
		else $error("sleep clock or monitor state wrong");
	a_wdt_kept: assert property ($rose(mode_out == PMC_SLEEP) |-> !watchdog_clear_out)
		else $error("watchdog cleared on sleep entry");
	a_idle_hold: assert property (quiet ##1 mode_out == PMC_IDLE |=> mode_out == PMC_IDLE)
		else $error("idle left without a waking event");
	a_idle_clocks: assert property (mode_out == PMC_IDLE |-> system_clock_run_out
		&& system_clock_domain_run_out && (periph_clk_en_out & stop_in_idle_in) == '0)
		else $error("idle clock gating wrong");
	a_read_done: assert property (periph_read_req_in && clk_en_in && mode_out == PMC_RUN
		|-> ##[1:9] periph_read_done_out)
		else $error("peripheral read never completed");
	a_div8_gap: assert property ((peripheral_clock_divisor_in == PMC_DIV_BY8)[*3] ##0
		peripheral_bus_clock_en_out |=> (!peripheral_bus_clock_en_out)[*7])
		else $error("bus clock tick early at divide by eight");
	a_deep_keep: assert property (mode_out == PMC_DEEP |-> always_retained_store_on_out
		&& master_clear_filter_on_out && !core_power_on_out)
		else $error("deep sleep power state wrong");
	a_backup_wdt: assert property (mode_out == PMC_BACKUP |-> !deep_sleep_watchdog_on_out
		&& always_retained_store_on_out)
		else $error("backup mode watchdog or store wrong");
	a_por_once: assert property (power_on_reset_out |=> !power_on_reset_out)
		else $error("power-on reset pulse too long");
	c_idle: cover property (mode_out == PMC_IDLE);
	c_sleep: cover property (mode_out == PMC_SLEEP);
	c_deep: cover property (mode_out == PMC_DEEP);
	c_backup: cover property (mode_out == PMC_BACKUP);
endmodule

// *** testbench/tb_power_mode_controller.sv ***
/* bench for the power-mode controller: the core model issues halts and reads,
   the bench drives interrupts, resets, supply and mode bits at falling edges. */
`timescale 1ns/10ps
module tb_power_mode_controller;
	import pmc_pkg::*;
	localparam int unsigned NUM_PERIPH = 8;
	localparam int unsigned OSC = 4;
	logic core_clk_in = 1'b0, resetn_in = 1'b0, clk_en_in = 1'b1, halt_instr_in;
	logic sleep_on_wait_select_in = 1'b0, deep_sleep_select_in = 1'b0, periph_read_req_in;
	logic calendar_off_in_deep_sleep_in = 1'b0, retained_store_enable_in = 1'b0;
	logic deep_watchdog_enable_in = 1'b0, irq_pending_in = 1'b0, irq_sleep_capable_in = 1'b0;
	logic [1:0] peripheral_clock_divisor_in = 2'h0;
	logic [NUM_PERIPH-1:0] stop_in_idle_in = 8'h00, periph_clk_en_out;
	logic [PMC_PRIO_W-1:0] irq_priority_in = 3'h0, cpu_priority_in = 3'h0;
	logic device_reset_in = 1'b0, watchdog_timeout_in = 1'b0, src_needs_osc_start_in = 1'b0;
	logic src_uses_pll_in = 1'b0, main_supply_good_in = 1'b1, master_clear_pin_in = 1'b1;
	logic external_interrupt_zero_in = 1'b0, cpu_halt_out, system_clock_run_out;
	logic peripheral_bus_clock_en_out, system_clock_domain_run_out, periph_read_done_out;
	logic fail_safe_clock_monitor_en_out, brownout_reset_en_out, watchdog_clear_out;
	logic core_power_on_out, calendar_clock_on_out, deep_sleep_watchdog_on_out;
	logic retained_store_bank_on_out, always_retained_store_on_out, master_clear_filter_on_out;
	logic ext_int_zero_wake_out, power_on_reset_out;
	logic [2:0] mode_out;
	int num_errors = 0, comparisons = 0, seed = 49, n;
	always #25 core_clk_in = ~core_clk_in;
	pmc_power_mode_controller #(.OSC_START_CYC(OSC), .PLL_LOCK_CYC(2)) pmc_power_mode_controller_i (.*);
	pmc_core_model pmc_core_model_i (.core_clk_in(core_clk_in), .cpu_halt_in(cpu_halt_out),
		.halt_instr_out(halt_instr_in), .periph_read_req_out(periph_read_req_in));
	task automatic tally_and_finish();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cycles(input int k);
		repeat (k) @(negedge core_clk_in);
	endtask
	task automatic wait_mode(input pmc_state_e m, input int bound);
		for (int i = 0; i < bound && mode_out !== m; i++) @(negedge core_clk_in);
		check("mode", m, mode_out);
		if (mode_out !== m) tally_and_finish();
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cycles(1);
		s = 1'b0;
	endtask
	task automatic set_irq(input logic p, input logic cap, input int ip, input int cp);
		irq_pending_in = p;
		irq_sleep_capable_in = cap;
		irq_priority_in = ip[2:0];
		cpu_priority_in = cp[2:0];
	endtask
	initial begin
		cycles(12);
		resetn_in = 1'b1;
		cycles(10);
		check("mode", PMC_RUN, mode_out);
		stop_in_idle_in = $random(seed);
		pmc_core_model_i.issue(1'b0);
		wait_mode(PMC_IDLE, 6);
		check("periph_en", ~stop_in_idle_in, periph_clk_en_out);
		set_irq(1'b1, 1'b0, 3, 5);
		cycles(6);
		check("mode", PMC_IDLE, mode_out);
		clk_en_in = 1'b0;
		set_irq(1'b1, 1'b0, 6, 5);
		cycles(4);
		check("frozen", PMC_IDLE, mode_out);
		clk_en_in = 1'b1;
		wait_mode(PMC_RUN, 6);
		set_irq(1'b0, 1'b0, 0, 0);
		pmc_core_model_i.issue(1'b0);
		wait_mode(PMC_IDLE, 6);
		pulse(watchdog_timeout_in);
		wait_mode(PMC_RUN, 6);
		sleep_on_wait_select_in = 1'b1;
		src_needs_osc_start_in = 1'b1;
		src_uses_pll_in = 1'b1;
		pmc_core_model_i.issue(1'b0);
		wait_mode(PMC_SLEEP, 6);
		check("system_clock_run", 0, system_clock_run_out);
		check("fail_safe_clock_monitor_bor", 1, {fail_safe_clock_monitor_en_out, brownout_reset_en_out});
		set_irq(1'b1, 1'b1, 2, 4);
		n = 0;
		for (int i = 0; i < 60 && mode_out !== PMC_IDLE; i++) begin
			@(negedge core_clk_in);
			n += (mode_out === PMC_WAKEUP);
		end
		check("osc_wait", 1, n >= OSC);
		wait_mode(PMC_IDLE, 1);
		set_irq(1'b0, 1'b0, 0, 0);
		pulse(device_reset_in);
		wait_mode(PMC_RUN, 8);
		src_needs_osc_start_in = 1'b0;
		src_uses_pll_in = 1'b0;
		pmc_core_model_i.issue(1'b0);
		wait_mode(PMC_SLEEP, 6);
		pulse(watchdog_timeout_in);
		wait_mode(PMC_RUN, 20);
		pmc_core_model_i.issue(1'b0);
		wait_mode(PMC_SLEEP, 6);
		set_irq(1'b1, 1'b1, 7, 1);
		wait_mode(PMC_RUN, 20);
		set_irq(1'b0, 1'b0, 0, 0);
		deep_sleep_select_in = 1'b1;
		for (int k = 0; k < 3; k++) begin
			{calendar_off_in_deep_sleep_in, retained_store_enable_in, deep_watchdog_enable_in} = $random(seed);
			pmc_core_model_i.issue(1'b0);
			wait_mode(PMC_DEEP, 6);
			check("calendar", !calendar_off_in_deep_sleep_in, calendar_clock_on_out);
			check("deep_wdt", deep_watchdog_enable_in, deep_sleep_watchdog_on_out);
			check("bank", retained_store_enable_in, retained_store_bank_on_out);
			check("external_interrupt_zero_idle", 0, ext_int_zero_wake_out);
			if (k == 0) begin
				pulse(device_reset_in);
			end else if (k == 1) begin
				pulse(external_interrupt_zero_in);
			end else begin
				master_clear_pin_in = 1'b0;
				cycles(1);
				master_clear_pin_in = 1'b1;
			end
			n = 0;
			for (int i = 0; i < 10 && mode_out !== PMC_RUN; i++) begin
				@(negedge core_clk_in);
				n += (ext_int_zero_wake_out === 1'b1);
			end
			check("external_interrupt_zero_wake", k == 1, n);
			wait_mode(PMC_RUN, 1);
		end
		deep_sleep_select_in = 1'b0;
		main_supply_good_in = 1'b0;
		wait_mode(PMC_BACKUP, 10);
		check("bk_bank", retained_store_enable_in, retained_store_bank_on_out);
		check("bk_cal", !calendar_off_in_deep_sleep_in, calendar_clock_on_out);
		main_supply_good_in = 1'b1;
		n = 0;
		for (int i = 0; i < 20; i++) begin
			@(negedge core_clk_in);
			n += (power_on_reset_out === 1'b1);
		end
		check("por_pulses", 1, n);
		wait_mode(PMC_RUN, 4);
		for (int d = 0; d < 4; d++) begin
			peripheral_clock_divisor_in = d[1:0];
			cycles(4);
			n = 0;
			repeat (16) begin
				@(negedge core_clk_in);
				n += (peripheral_bus_clock_en_out === 1'b1);
			end
			check("ticks", 16 >> d, n);
			check("sys_domain", 1, system_clock_domain_run_out);
			repeat (3) begin
				cycles($unsigned($random(seed)) % 5);
				pmc_core_model_i.issue(1'b1);
				n = 0;
				for (int i = 0; i < 12 && periph_read_done_out !== 1'b1; i++) begin
					@(negedge core_clk_in);
					n++;
				end
				check("read_lat", 1, n < (1 << d));
			end
		end
		tally_and_finish();
	end
endmodule
bind pmc_power_mode_controller pmc_checker #(.NUM_PERIPH(NUM_PERIPH)) pmc_checker_i (.*);
